// File: fiap_params.svh
`ifndef FIAP_PARAMS_SVH
`define FIAP_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FIAP_OFS_CTRL      8'h00
`define FIAP_OFS_ADDR_LO   8'h04
`define FIAP_OFS_ADDR_HI   8'h08
`define FIAP_OFS_WORD_LO   8'h0C
`define FIAP_OFS_WORD_HI   8'h10
`define FIAP_OFS_KEY_BASE  8'h14
`define FIAP_OFS_RDCTL     8'h2C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FIAP_CTRL_MODE_LSB    0
`define FIAP_CTRL_PROG_BIT    3
`define FIAP_CTRL_READ_BIT    4
`define FIAP_CTRL_RDEN_BIT    5
`define FIAP_CTRL_UNLOCK_BIT  6
`define FIAP_CTRL_UNLKD_BIT   7
`define FIAP_RDCTL_CLEAR_BIT  0

// ----------------------------------------
// Operation mode codes
// ----------------------------------------
`define FIAP_MODE_WRITE   3'b000
`define FIAP_MODE_ERASE   3'b001
`define FIAP_MODE_READ    3'b011
`define FIAP_MODE_UNLOCK  3'b110

// ----------------------------------------
// Flash array command codes
// ----------------------------------------
`define FIAP_CMD_ERASE    2'b01
`define FIAP_CMD_PROGRAM  2'b10
`define FIAP_CMD_READ     2'b11

// ----------------------------------------
// Unlock key, low bytes then high bytes
// ----------------------------------------
`define FIAP_KEY0 8'h00
`define FIAP_KEY1 8'h0D
`define FIAP_KEY2 8'hC3
`define FIAP_KEY3 8'h04
`define FIAP_KEY4 8'h09
`define FIAP_KEY5 8'h40

// ----------------------------------------
// Sizes, reset values and timing
// ----------------------------------------
`define FIAP_PAGE_WORDS      64
`define FIAP_RESET_BYTE      8'h00
`define FIAP_CLK_MHZ         20
`define FIAP_UNLOCK_WINDOW_US 1000
`define FIAP_UNLOCK_CYCLES   (`FIAP_UNLOCK_WINDOW_US * `FIAP_CLK_MHZ)

`endif

// File: fiap_pkg.sv
package fiap_pkg;

    typedef enum logic [2:0] {
        FIAP_IDLE,
        FIAP_ERASE,
        FIAP_PROG,
        FIAP_READ,
        FIAP_CLEAR
    } fiap_state_type;

endpackage

// File: fiap_window_timer.sv
`timescale 1ns/1ps

module fiap_window_timer #(
    parameter int CYCLES = 20000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    output logic active,
    output logic expire
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_q;

    // ----------------------------------------
    // Countdown from start to expiry
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (start) begin
            count_q <= CW'(CYCLES);
        end else if (count_q != '0) begin
            count_q <= count_q - CW'(1);
        end
    end

    assign active = (count_q != '0);
    assign expire = (count_q == CW'(1));

endmodule

// File: fiap_page_programmer.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fiap_params.svh"


module fiap_page_programmer #(
    parameter int PAGE_WORDS = `FIAP_PAGE_WORDS,
    parameter int UNLOCK_CYCLES = `FIAP_UNLOCK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash array
    output logic flash_req,
    output logic [1:0] flash_cmd,
    output logic [15:0] flash_addr,
    output logic [15:0] flash_wdata,
    input wire logic flash_ack,
    input wire logic [15:0] flash_rdata,
    // CPU
    output logic cpu_stall
);

    localparam int IW = $clog2(PAGE_WORDS);
    localparam logic [IW-1:0] LAST_IDX = IW'(PAGE_WORDS - 1);
    localparam logic [7:0] KEY [6] = '{`FIAP_KEY0, `FIAP_KEY1, `FIAP_KEY2,
                                       `FIAP_KEY3, `FIAP_KEY4, `FIAP_KEY5};

    fiap_pkg::fiap_state_type state_q;
    logic [2:0] op_select_q;
    logic program_trigger_q;
    logic read_trigger_q;
    logic read_path_enable_q;
    logic unlock_trigger_q;
    logic erase_write_unlocked_q;
    logic [15:0] addr_q;
    logic [7:0] word_lo_q;
    logic [7:0] word_hi_q;
    logic [7:0] key_q [6];
    logic [7:1] rdctl_q;
    logic buffer_clear_request_q;
    logic [IW-1:0] idx_q;
    logic flash_req_q;
    logic [1:0] flash_cmd_q;
    logic [15:0] flash_addr_q;
    logic [15:0] flash_wdata_q;
    logic [15:0] buf_mem [PAGE_WORDS];

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic mapped;
    logic idle;
    logic wr_ctrl;
    logic key_hit;
    logic key_match;
    logic timer_active;
    logic timer_expire;
    logic [2:0] wmode;
    logic start_erase;
    logic start_prog;
    logic start_read;
    logic start_unlock;
    logic start_clear;
    logic load_word;
    logic op_done;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign idle = (state_q == fiap_pkg::FIAP_IDLE);
    assign wr_ctrl = wr && (paddr == `FIAP_OFS_CTRL) && idle;
    assign wmode = pwdata[`FIAP_CTRL_MODE_LSB +: 3];

    always_comb begin
        key_hit = 1'b0;
        key_match = 1'b1;
        for (int k = 0; k < 6; k++) begin
            if (paddr == 8'(`FIAP_OFS_KEY_BASE + 4 * k)) begin
                key_hit = 1'b1;
            end
            if (key_q[k] != KEY[k]) begin
                key_match = 1'b0;
            end
        end
    end

    always_comb begin
        case (paddr)
            `FIAP_OFS_CTRL, `FIAP_OFS_ADDR_LO, `FIAP_OFS_ADDR_HI,
            `FIAP_OFS_WORD_LO, `FIAP_OFS_WORD_HI, `FIAP_OFS_RDCTL: mapped = 1'b1;
            default: mapped = key_hit;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // locked device ignores erase and write
    assign start_erase = wr_ctrl && pwdata[`FIAP_CTRL_PROG_BIT] && erase_write_unlocked_q
                         && (wmode == `FIAP_MODE_ERASE);
    assign start_prog = wr_ctrl && pwdata[`FIAP_CTRL_PROG_BIT] && erase_write_unlocked_q
                        && (wmode == `FIAP_MODE_WRITE);
    assign start_read = wr_ctrl && pwdata[`FIAP_CTRL_READ_BIT] && pwdata[`FIAP_CTRL_RDEN_BIT]
                        && (wmode == `FIAP_MODE_READ);
    assign start_unlock = wr_ctrl && pwdata[`FIAP_CTRL_UNLOCK_BIT]
                          && (wmode == `FIAP_MODE_UNLOCK) && !unlock_trigger_q;
    assign start_clear = wr && idle && (paddr == `FIAP_OFS_RDCTL)
                         && pwdata[`FIAP_RDCTL_CLEAR_BIT];
    assign load_word = wr && idle && (paddr == `FIAP_OFS_WORD_HI);
    assign op_done = flash_req_q && flash_ack
                     && ((state_q != fiap_pkg::FIAP_PROG) || (idx_q == LAST_IDX));

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `FIAP_OFS_CTRL: prdata[7:0] = {erase_write_unlocked_q, unlock_trigger_q,
                                           read_path_enable_q, read_trigger_q,
                                           program_trigger_q, op_select_q};
            `FIAP_OFS_ADDR_LO: prdata[7:0] = addr_q[7:0];
            `FIAP_OFS_ADDR_HI: prdata[7:0] = addr_q[15:8];
            `FIAP_OFS_WORD_LO: prdata[7:0] = word_lo_q;
            `FIAP_OFS_WORD_HI: prdata[7:0] = word_hi_q;
            `FIAP_OFS_RDCTL: prdata[7:0] = {rdctl_q, buffer_clear_request_q};
            default: begin
                for (int k = 0; k < 6; k++) begin
                    if (paddr == 8'(`FIAP_OFS_KEY_BASE + 4 * k)) begin
                        prdata[7:0] = key_q[k];
                    end
                end
            end
        endcase
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_select_q <= 3'h0;
            read_path_enable_q <= 1'b0;
        end else if (wr_ctrl) begin
            op_select_q <= wmode;
            read_path_enable_q <= pwdata[`FIAP_CTRL_RDEN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_trigger_q <= 1'b0;
            read_trigger_q <= 1'b0;
        end else begin
            if (start_erase || start_prog) begin
                program_trigger_q <= 1'b1;
            end else if (op_done && (state_q != fiap_pkg::FIAP_READ)) begin
                program_trigger_q <= 1'b0;
            end
            if (start_read) begin
                read_trigger_q <= 1'b1;
            end else if (op_done && (state_q == fiap_pkg::FIAP_READ)) begin
                read_trigger_q <= 1'b0;
            end
        end
    end

    assign cpu_stall = program_trigger_q || read_trigger_q;

    // ----------------------------------------
    // Unlock window and key
    // ----------------------------------------
    fiap_window_timer #(
        .CYCLES(UNLOCK_CYCLES)
    ) u_window (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_unlock),
        .active(timer_active),
        .expire(timer_expire)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_trigger_q <= 1'b0;
        end else if (start_unlock) begin
            unlock_trigger_q <= 1'b1;
        end else if (timer_expire) begin
            unlock_trigger_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 6; k++) begin
                key_q[k] <= `FIAP_RESET_BYTE;
            end
        end else if (start_unlock) begin
            for (int k = 0; k < 6; k++) begin
                key_q[k] <= 8'hFF;
            end
        end else if (wr) begin
            for (int k = 0; k < 6; k++) begin
                if (paddr == 8'(`FIAP_OFS_KEY_BASE + 4 * k)) begin
                    key_q[k] <= pwdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_write_unlocked_q <= 1'b0;
        end else if (unlock_trigger_q && timer_active && key_match) begin
            erase_write_unlocked_q <= 1'b1;
        end else if (wr_ctrl && !pwdata[`FIAP_CTRL_UNLKD_BIT]) begin
            erase_write_unlocked_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Address pair and data registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 16'h0000;
        end else if (wr && idle && (paddr == `FIAP_OFS_ADDR_LO)) begin
            addr_q[7:0] <= pwdata[7:0];
        end else if (wr && idle && (paddr == `FIAP_OFS_ADDR_HI)) begin
            addr_q[15:8] <= pwdata[7:0];
        end else if (load_word && (addr_q[IW-1:0] != LAST_IDX)) begin
            addr_q[IW-1:0] <= addr_q[IW-1:0] + IW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_lo_q <= `FIAP_RESET_BYTE;
            word_hi_q <= `FIAP_RESET_BYTE;
        end else if (op_done && (state_q == fiap_pkg::FIAP_READ)) begin
            word_lo_q <= flash_rdata[7:0];
            word_hi_q <= flash_rdata[15:8];
        end else if (wr && idle && (paddr == `FIAP_OFS_WORD_LO)) begin
            word_lo_q <= pwdata[7:0];
        end else if (load_word) begin
            word_hi_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdctl_q <= 7'h00;
            buffer_clear_request_q <= 1'b0;
        end else begin
            if (wr && idle && (paddr == `FIAP_OFS_RDCTL)) begin
                rdctl_q <= pwdata[7:1];
            end
            if (start_clear) begin
                buffer_clear_request_q <= 1'b1;
            end else if ((state_q == fiap_pkg::FIAP_CLEAR) && (idx_q == LAST_IDX)) begin
                buffer_clear_request_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Page buffer
    // ----------------------------------------
    always_ff @(posedge pclk) begin
        if (state_q == fiap_pkg::FIAP_CLEAR) begin
            buf_mem[idx_q] <= 16'h0000;
        end else if (load_word) begin
            buf_mem[addr_q[IW-1:0]] <= {pwdata[7:0], word_lo_q};
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fiap_pkg::FIAP_IDLE;
            idx_q <= '0;
            flash_req_q <= 1'b0;
            flash_cmd_q <= 2'b00;
            flash_addr_q <= 16'h0000;
            flash_wdata_q <= 16'h0000;
        end else begin
            case (state_q)
                fiap_pkg::FIAP_IDLE: begin
                    idx_q <= '0;
                    if (start_erase) begin
                        state_q <= fiap_pkg::FIAP_ERASE;
                        flash_req_q <= 1'b1;
                        flash_cmd_q <= `FIAP_CMD_ERASE;
                        flash_addr_q <= {addr_q[15:IW], IW'(0)};
                    end else if (start_prog) begin
                        state_q <= fiap_pkg::FIAP_PROG;
                        flash_req_q <= 1'b1;
                        flash_cmd_q <= `FIAP_CMD_PROGRAM;
                        flash_addr_q <= {addr_q[15:IW], IW'(0)};
                        flash_wdata_q <= buf_mem[0];
                    end else if (start_read) begin
                        state_q <= fiap_pkg::FIAP_READ;
                        flash_req_q <= 1'b1;
                        flash_cmd_q <= `FIAP_CMD_READ;
                        flash_addr_q <= addr_q;
                    end else if (start_clear) begin
                        state_q <= fiap_pkg::FIAP_CLEAR;
                    end
                end
                fiap_pkg::FIAP_PROG: begin
                    // one page image, stops at boundary
                    if (flash_ack && (idx_q == LAST_IDX)) begin
                        state_q <= fiap_pkg::FIAP_IDLE;
                        flash_req_q <= 1'b0;
                    end else if (flash_ack) begin
                        idx_q <= idx_q + IW'(1);
                        flash_addr_q <= {addr_q[15:IW], idx_q + IW'(1)};
                        flash_wdata_q <= buf_mem[idx_q + IW'(1)];
                    end
                end
                fiap_pkg::FIAP_ERASE, fiap_pkg::FIAP_READ: begin
                    if (flash_ack) begin
                        state_q <= fiap_pkg::FIAP_IDLE;
                        flash_req_q <= 1'b0;
                    end
                end
                fiap_pkg::FIAP_CLEAR: begin
                    if (idx_q == LAST_IDX) begin
                        state_q <= fiap_pkg::FIAP_IDLE;
                    end
                    idx_q <= idx_q + IW'(1);
                end
                default: begin
                    state_q <= fiap_pkg::FIAP_IDLE;
                    flash_req_q <= 1'b0;
                end
            endcase
        end
    end

    assign flash_req = flash_req_q;
    assign flash_cmd = flash_cmd_q;
    assign flash_addr = flash_addr_q;
    assign flash_wdata = flash_wdata_q;

endmodule

// File: fiap_flash_model.sv
`timescale 1ns/1ps

module fiap_flash_model #(
    parameter int PAGE_WORDS = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request from the sequencer
    input wire logic flash_req,
    input wire logic [1:0] flash_cmd,
    input wire logic [15:0] flash_addr,
    input wire logic [15:0] flash_wdata,
    // Answer
    output logic flash_ack,
    output logic [15:0] flash_rdata
);
    logic [15:0] mem [0:4095];
    logic [2:0] wait_q;
    logic [15:0] last_q;
    int base;

    // ----------------------------------------
    // Array contents and answer timing
    // ----------------------------------------
    // Known pattern so untouched words can be told apart
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = {8'(i) ^ 8'h5a, 8'(i)};
        end
    end

    // Odd addresses answer slowly, even ones at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_ack <= 1'b0;
            wait_q <= 3'h0;
            last_q <= 16'h0000;
            flash_rdata <= 16'h0000;
        end else begin
            flash_ack <= 1'b0;
            flash_rdata <= ~last_q;
            if (flash_req && !flash_ack) begin
                if (wait_q == (flash_addr[0] ? 3'h3 : 3'h0)) begin
                    flash_ack <= 1'b1;
                    wait_q <= 3'h0;
                    base = (int'(flash_addr[11:0]) / PAGE_WORDS) * PAGE_WORDS;
                    // whole-page erase, program one word, read word
                    case (flash_cmd)
                        2'b01: for (int j = 0; j < PAGE_WORDS; j++) mem[base + j] <= 16'h0000;
                        2'b10: mem[flash_addr[11:0]] <= flash_wdata;
                        2'b11: begin
                            flash_rdata <= mem[flash_addr[11:0]];
                            last_q <= mem[flash_addr[11:0]];
                        end
                        default: ;
                    endcase
                end else begin
                    wait_q <= wait_q + 3'h1;
                end
            end
        end
    end
endmodule

// File: fiap_page_programmer_assertions.sv
`timescale 1ns/1ps

module fiap_page_programmer_checker #(
    parameter int PAGE_WORDS = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Flash side and stall
    input wire logic flash_req,
    input wire logic [1:0] flash_cmd,
    input wire logic [15:0] flash_addr,
    input wire logic [15:0] flash_wdata,
    input wire logic flash_ack,
    input wire logic cpu_stall
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stall_prog:
        assert property ($rose(flash_req) && flash_cmd == 2'b10 |-> cpu_stall)
        else $error("no stall at program start");
    a_stall_read:
        assert property ($rose(flash_req) && flash_cmd == 2'b11 |-> cpu_stall)
        else $error("no stall at read start");
    a_stall_needs_op:
        assert property (cpu_stall |-> ##[0:1] flash_req)
        else $error("stall without flash operation");
    a_erase_page_base:
        assert property (flash_req && flash_cmd == 2'b01 |-> flash_addr % PAGE_WORDS == 0)
        else $error("erase not at page base");
    a_prog_addr_step:
        assert property (flash_req && flash_ack && flash_cmd == 2'b10
            && flash_addr % PAGE_WORDS != PAGE_WORDS - 1
            |=> flash_req && flash_cmd == 2'b10 && flash_addr == $past(flash_addr) + 16'h0001)
        else $error("program word address did not step");
    a_prog_end_release:
        assert property (flash_req && flash_ack && flash_cmd == 2'b10
            && flash_addr % PAGE_WORDS == PAGE_WORDS - 1 |=> !cpu_stall ##[0:1] !flash_req)
        else $error("program did not finish at page end");
    a_erase_done:
        assert property (flash_req && flash_ack && flash_cmd == 2'b01 |=> !cpu_stall)
        else $error("erase trigger not cleared");
    a_read_done:
        assert property (flash_req && flash_ack && flash_cmd == 2'b11 |=> !cpu_stall)
        else $error("read trigger not cleared");
    a_req_holds:
        assert property (flash_req && !flash_ack && cpu_stall |=> flash_req
            && $stable(flash_addr) && $stable(flash_cmd) && $stable(flash_wdata))
        else $error("flash request changed before answer");
endmodule

bind fiap_page_programmer fiap_page_programmer_checker #(
    .PAGE_WORDS(PAGE_WORDS)
) fiap_page_programmer_checker_i (
    .pclk(pclk),
    .presetn(presetn),
    .flash_req(flash_req),
    .flash_cmd(flash_cmd),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata),
    .flash_ack(flash_ack),
    .cpu_stall(cpu_stall)
);

// File: fiap_page_programmer_tb_top.sv
`timescale 1ns/1ps
`include "fiap_params.svh"

module fiap_page_programmer_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic flash_req, flash_ack, cpu_stall;
    logic [1:0] flash_cmd;
    logic [15:0] flash_addr, flash_wdata, flash_rdata, d;
    logic [7:0] key [6];
    int errors, compares;

    fiap_page_programmer #(.PAGE_WORDS(64), .UNLOCK_CYCLES(50)) fiap_page_programmer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
        .cpu_stall(cpu_stall));
    fiap_flash_model #(.PAGE_WORDS(64)) fiap_flash_model_i (
        .pclk(pclk), .presetn(presetn), .flash_req(flash_req), .flash_cmd(flash_cmd),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));

    // ----------------------------------------
    // Clock, helpers and bus tasks
    // ----------------------------------------
    // full-rate system clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [15:0] init_val(input logic [15:0] a);
        return {a[7:0] ^ 8'h5a, a[7:0]};
    endfunction

    task conclude();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(v);
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 8'h00);
            n++;
        end while (r[b] !== 1'b0 && n < 200);
        chk("self-clearing bit", 32'h0000_0000, 32'(r[b]));
    endtask

    // Word read through the address pair; bit 7 kept so an unlock survives
    task read_trigger(input logic [15:0] a, input logic [15:0] exp);
        apb(1'b1, 8'h04, a[7:0]);
        apb(1'b1, 8'h08, a[15:8]);
        apb(1'b1, 8'h00, 8'hb3);
        poll(8'h00, 4);
        apb(1'b0, 8'h0c, 8'h00);
        d[7:0] = r[7:0];
        apb(1'b0, 8'h10, 8'h00);
        d[15:8] = r[7:0];
        chk("flash word", 32'(exp), 32'(d));
    endtask

    task unlock(input logic [7:0] last);
        apb(1'b1, 8'h00, 8'h46);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 8'(8'h14 + 4 * k), (k == 5) ? last : key[k]);
        end
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        conclude();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errors = 0;
        compares = 0;
        key = '{`FIAP_KEY0, `FIAP_KEY1, `FIAP_KEY2, `FIAP_KEY3, `FIAP_KEY4, `FIAP_KEY5};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 8'h00);
        chk("control reset", 32'h0000_0000, r);
        apb(1'b0, 8'h2c, 8'h00);
        chk("read control reset", 32'h0000_0000, r);
        apb(1'b0, 8'h30, 8'h00);
        chk("unmapped error", 32'h0000_0001, 32'(e));
        apb(1'b1, 8'h00, 8'h89);
        repeat (4) @(posedge pclk);
        chk("locked request", 32'h0000_0000, 32'(flash_req));
        apb(1'b0, 8'h00, 8'h00);
        chk("locked trigger", 32'h0000_0000, 32'(r[3]));
        read_trigger(16'h0005, init_val(16'h0005));
        unlock(8'h41);
        poll(8'h00, 6);
        chk("wrong key flag", 32'h0000_0000, 32'(r[7]));
        unlock(key[5]);
        apb(1'b0, 8'h00, 8'h00);
        chk("unlock flag", 32'h0000_0001, 32'(r[7]));
        poll(8'h00, 6);
        apb(1'b1, 8'h04, 8'h45);
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h00, 8'h89);
        poll(8'h00, 3);
        read_trigger(16'h0040, 16'h0000);
        read_trigger(16'h007f, 16'h0000);
        apb(1'b1, 8'h2c, 8'h01);
        poll(8'h2c, 0);
        apb(1'b1, 8'h04, 8'h40);
        apb(1'b1, 8'h08, 8'h00);
        // One load past the page end must land on the last word
        for (int i = 0; i < 65; i++) begin
            apb(1'b1, 8'h0c, 8'(i));
            apb(1'b1, 8'h10, 8'h3c);
        end
        apb(1'b1, 8'h00, 8'h88);
        poll(8'h00, 3);
        read_trigger(16'h0041, 16'h3c01);
        read_trigger(16'h007f, 16'h3c40);
        read_trigger(16'h0080, init_val(16'h0080));
        // Scattered word: clear buffer, new address, rewrite page without erase
        apb(1'b1, 8'h2c, 8'h01);
        poll(8'h2c, 0);
        apb(1'b1, 8'h04, 8'h45);
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h0c, 8'h77);
        apb(1'b1, 8'h10, 8'h21);
        apb(1'b1, 8'h00, 8'h88);
        poll(8'h00, 3);
        read_trigger(16'h0045, 16'h2177);
        read_trigger(16'h0046, 16'h0000);
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        chk("flag cleared", 32'h0000_0000, 32'(r[7]));
        conclude();
    end
endmodule
